/* File: include/vmadc_defs.vh */
// Register map, field positions, reset values and timing counts of the voltage monitor
`ifndef VMADC_DEFS_VH
`define VMADC_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VMADC_OFS_READING    8'h20
`define VMADC_OFS_CONFIG     8'h40
`define VMADC_OFS_STATUS     8'h41
`define VMADC_OFS_LOW_LIMIT  8'h44
`define VMADC_OFS_HIGH_LIMIT 8'h45

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VMADC_RST_READING    8'h00
`define VMADC_RST_CONFIG     8'h00
`define VMADC_RST_LOW_LIMIT  8'h00
`define VMADC_RST_HIGH_LIMIT 8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VMADC_CFG_ALERT_EN   1
`define VMADC_CFG_SCALE_5V   7
`define VMADC_STS_LOW        0
`define VMADC_STS_HIGH       1

// ----------------------------------------
// Converter and timing
// ----------------------------------------
`define VMADC_ADC_BITS       10
`define VMADC_AVG_SAMPLES    16
`define VMADC_AVG_SHIFT      4
`define VMADC_CLK_PERIOD_PS  8000
`define VMADC_CONV_TIME_PS   711000000
`define VMADC_CONV_CYCLES    (`VMADC_CONV_TIME_PS / `VMADC_CLK_PERIOD_PS)
`define VMADC_TRACK_CYCLES   8
`define VMADC_SETTLE_CYCLES  4

`endif

/* File: src/vmadc_sar.v */
// Successive-approximation register engine for the shared converter
`include "vmadc_defs.vh"

module vmadc_sar #(
   parameter N_BITS     = `VMADC_ADC_BITS,
   parameter TRACK_CYC  = `VMADC_TRACK_CYCLES,
   parameter SETTLE_CYC = `VMADC_SETTLE_CYCLES
) (
   input  wire              ref_clk,
   input  wire              rst,
   input  wire              start,
   input  wire              comp_ge,
   output reg               sample_en,
   output reg  [N_BITS-1:0] dac_code,
   output reg               done,
   output reg  [N_BITS-1:0] result
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [2:0] S_IDLE  = 3'b001;
   localparam [2:0] S_TRACK = 3'b010;
   localparam [2:0] S_BIT   = 3'b100;

   reg [2:0]        state_reg;
   reg [7:0]        wait_reg;
   reg [3:0]        bit_reg;
   reg [N_BITS-1:0] trial;

   always @* begin
      trial = dac_code;
      // Keep the trial bit only if the input reaches it
      if (!comp_ge) begin
         trial[bit_reg] = 1'b0;
      end
   end

   // ----------------------------------------
   // Bit trials
   // ----------------------------------------
   // Settle time covers the two-flop comparator synchroniser
   always @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= S_IDLE;
         wait_reg  <= 8'h00;
         bit_reg   <= 4'h0;
         sample_en <= 1'b0;
         dac_code  <= {N_BITS{1'b0}};
         done      <= 1'b0;
         result    <= {N_BITS{1'b0}};
      end else begin
         done <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (start) begin
                  sample_en <= 1'b1;
                  wait_reg  <= TRACK_CYC[7:0];
                  state_reg <= S_TRACK;
               end
            end
            S_TRACK: begin
               if (wait_reg == 8'h00) begin
                  sample_en <= 1'b0;
                  bit_reg   <= N_BITS[3:0] - 4'h1;
                  dac_code  <= {1'b1, {(N_BITS-1){1'b0}}};
                  wait_reg  <= SETTLE_CYC[7:0];
                  state_reg <= S_BIT;
               end else begin
                  wait_reg <= wait_reg - 8'h01;
               end
            end
            S_BIT: begin
               if (wait_reg != 8'h00) begin
                  wait_reg <= wait_reg - 8'h01;
               end else if (bit_reg == 4'h0) begin
                  // Straight binary; full-scale input leaves all ones
                  result    <= trial;
                  dac_code  <= {N_BITS{1'b0}};
                  done      <= 1'b1;
                  state_reg <= S_IDLE;
               end else begin
                  dac_code              <= trial;
                  dac_code[bit_reg-4'h1] <= 1'b1;
                  bit_reg               <= bit_reg - 4'h1;
                  wait_reg              <= SETTLE_CYC[7:0];
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: src/vmadc_monitor.v */
// Voltage monitor: conversion sequencing, averaging, reading register and limit checks
//
// Overview of operation
// - Both inputs share one multiplexer into one 10-bit successive-approximation converter.
// - Only the 2.5 V input and the device supply are measured.
// - Nominal input gives code 768, three-quarter scale, leaving overvoltage headroom.
// - One conversion every 711 us; sixteen conversions averaged per measurement.
// - An averaged measurement completes in nominally 11.38 ms before reporting.
// - Config bit 7 switches the supply channel to the 5 V scale.
// - Codes are straight binary and saturate at 1023.
// - The 2.5 V result is checked against low and high limits; status set.
// - A limit violation may drive the bus alert output.
// - Host reads status after alert; alert releases once the violation ends and status is read, or when config clears the alert enable.
`include "vmadc_defs.vh"

module vmadc_monitor #(
   parameter N_BITS      = `VMADC_ADC_BITS,
   parameter CONV_CYCLES = `VMADC_CONV_CYCLES
) (
   input  wire              ref_clk,
   input  wire              rst,
   input  wire [7:0]        reg_addr,
   input  wire              reg_wr,
   input  wire [7:0]        reg_wdata,
   input  wire              reg_rd,
   output reg  [7:0]        reg_rdata,
   input  wire              comp_ge_pin,
   output reg               mux_sel_supply,
   output reg               supply_scale_5v,
   output wire              sample_en,
   output wire [N_BITS-1:0] dac_code,
   output reg  [N_BITS-1:0] supply_reading,
   output reg               alert_oe
);

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   localparam [1:0] Q_WAIT = 2'b01;
   localparam [1:0] Q_CONV = 2'b10;

   reg [1:0]          seq_reg;
   reg [23:0]         period_reg;
   reg [3:0]          count_reg;
   reg [N_BITS+3:0]   accum_reg;
   reg                sync1_reg;
   reg                sync2_reg;
   reg                start_reg;
   reg [7:0]          reading_reg;
   reg [7:0]          config_reg;
   reg [7:0]          low_limit_reg;
   reg [7:0]          high_limit_reg;
   reg [1:0]          status_reg;
   reg [1:0]          viol_reg;
   reg [1:0]          viol_next;
   reg [N_BITS+3:0]   sum_next;
   reg [7:0]          msb_next;
   wire               sar_done;
   wire [N_BITS-1:0]  sar_result;

   // ----------------------------------------
   // Comparator synchroniser
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= comp_ge_pin;
         sync2_reg <= sync1_reg;
      end
   end

   vmadc_sar #(
      .N_BITS     (N_BITS),
      .TRACK_CYC  (`VMADC_TRACK_CYCLES),
      .SETTLE_CYC (`VMADC_SETTLE_CYCLES)
   ) u_sar (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .start     (start_reg),
      .comp_ge   (sync2_reg),
      .sample_en (sample_en),
      .dac_code  (dac_code),
      .done      (sar_done),
      .result    (sar_result)
   );

   // ----------------------------------------
   // Averaging and limit evaluation
   // ----------------------------------------
   always @* begin
      sum_next = accum_reg + {4'h0, sar_result};
      // Average of sixteen, eight top bits kept
      msb_next = sum_next[N_BITS+3:N_BITS-4];
      viol_next[`VMADC_STS_LOW]  = (msb_next < low_limit_reg);
      viol_next[`VMADC_STS_HIGH] = (msb_next > high_limit_reg);
   end

   // ----------------------------------------
   // Conversion sequencing
   // ----------------------------------------
   // Fixed period regardless of SAR length, so timing does not drift
   always @(posedge ref_clk) begin
      if (rst) begin
         seq_reg        <= Q_WAIT;
         period_reg     <= 24'h000000;
         count_reg      <= 4'h0;
         accum_reg      <= {(N_BITS+4){1'b0}};
         start_reg      <= 1'b0;
         mux_sel_supply <= 1'b0;
         reading_reg    <= `VMADC_RST_READING;
         supply_reading <= {N_BITS{1'b0}};
         viol_reg       <= 2'b00;
      end else begin
         start_reg <= 1'b0;
         if (period_reg == CONV_CYCLES[23:0] - 24'h000001) begin
            period_reg <= 24'h000000;
         end else begin
            period_reg <= period_reg + 24'h000001;
         end
         case (seq_reg)
            Q_WAIT: begin
               // One sample-and-convert per period
               if (period_reg == 24'h000000) begin
                  start_reg <= 1'b1;
                  seq_reg   <= Q_CONV;
               end
            end
            Q_CONV: begin
               if (sar_done) begin
                  seq_reg <= Q_WAIT;
                  if (count_reg == 4'hf) begin
                     // Sixteenth sample closes the measurement
                     count_reg <= 4'h0;
                     accum_reg <= {(N_BITS+4){1'b0}};
                     // Shared mux alternates the two channels
                     mux_sel_supply <= ~mux_sel_supply;
                     if (mux_sel_supply) begin
                        supply_reading <= sum_next[N_BITS+3:`VMADC_AVG_SHIFT];
                     end else begin
                        reading_reg <= msb_next;
                        viol_reg    <= viol_next;
                     end
                  end else begin
                     count_reg <= count_reg + 4'h1;
                     accum_reg <= sum_next;
                  end
               end
            end
            default: begin
               seq_reg <= Q_WAIT;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register access
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         config_reg     <= `VMADC_RST_CONFIG;
         low_limit_reg  <= `VMADC_RST_LOW_LIMIT;
         high_limit_reg <= `VMADC_RST_HIGH_LIMIT;
         reg_rdata      <= 8'h00;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `VMADC_OFS_CONFIG:     config_reg     <= reg_wdata;
               `VMADC_OFS_LOW_LIMIT:  low_limit_reg  <= reg_wdata;
               `VMADC_OFS_HIGH_LIMIT: high_limit_reg <= reg_wdata;
               default:               config_reg     <= config_reg;
            endcase
         end
         if (reg_rd) begin
            case (reg_addr)
               `VMADC_OFS_READING:    reg_rdata <= reading_reg;
               `VMADC_OFS_CONFIG:     reg_rdata <= config_reg;
               `VMADC_OFS_STATUS:     reg_rdata <= {6'h00, status_reg};
               `VMADC_OFS_LOW_LIMIT:  reg_rdata <= low_limit_reg;
               `VMADC_OFS_HIGH_LIMIT: reg_rdata <= high_limit_reg;
               default:               reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Status and alert
   // ----------------------------------------
   // Status read clears only bits whose violation has gone; a set wins
   always @(posedge ref_clk) begin
      if (rst) begin
         status_reg <= 2'b00;
         alert_oe   <= 1'b0;
      end else begin
         if (reg_rd && reg_addr == `VMADC_OFS_STATUS) begin
            status_reg <= viol_reg;
         end else begin
            status_reg <= status_reg | viol_reg;
         end
         // Pull the alert line while a flagged violation stands
         alert_oe <= config_reg[`VMADC_CFG_ALERT_EN] & (|status_reg);
      end
   end

   // ----------------------------------------
   // Supply scaling
   // ----------------------------------------
   // Registered copy keeps the attenuator pick free of decode glitches
   always @(posedge ref_clk) begin
      if (rst) begin
         supply_scale_5v <= 1'b0;
      end else begin
         // Attenuator pick keeps nominal supply near code 768
         supply_scale_5v <= config_reg[`VMADC_CFG_SCALE_5V];
      end
   end

endmodule

/* File: testbench/vmadc_afe_model.sv */
// Behavioural analog front end: channel multiplexer and comparator
module vmadc_afe_model #(
   parameter SETTLE_NS = 12
) (
   input  logic       mux_sel_supply,
   input  logic [9:0] dac_code,
   input  logic [9:0] vin_code,
   input  logic [9:0] vsup_code,
   output logic       comp_ge_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slow settle, still inside the three-cycle budget of a trial
   assign #(SETTLE_NS) comp_ge_pin = (mux_sel_supply ? vsup_code : vin_code) >= dac_code;
endmodule

/* File: testbench/vmadc_monitor_chk.sv */
// Port-level assertions for the voltage monitor
module vmadc_monitor_chk #(
   parameter N_BITS      = 10,
   parameter CONV_CYCLES = 88875
) (
   input logic              ref_clk,
   input logic              rst,
   input logic [7:0]        reg_addr,
   input logic              reg_wr,
   input logic [7:0]        reg_wdata,
   input logic              reg_rd,
   input logic [7:0]        reg_rdata,
   input logic              mux_sel_supply,
   input logic              supply_scale_5v,
   input logic              sample_en,
   input logic [N_BITS-1:0] dac_code,
   input logic              alert_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] per_reg;
   logic [4:0]  conv_reg;
   logic [2:0]  clr_reg;
   logic        en_reg;
   logic        seen_reg;
   wire         clr_hit = (reg_rd && reg_addr == 8'h41) || (reg_wr && reg_addr == 8'h40);
   default clocking dcb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Counters stand in for long repetitions
   always @(posedge ref_clk) begin
      if (rst) begin
         per_reg  <= 32'h0;
         conv_reg <= 5'h0;
         clr_reg  <= 3'h7;
         en_reg   <= 1'b0;
         seen_reg <= 1'b0;
      end else begin
         per_reg  <= $rose(sample_en) ? 32'h0 : per_reg + 32'h1;
         conv_reg <= $changed(mux_sel_supply) ? 5'h0 : conv_reg + {4'h0, $rose(sample_en)};
         clr_reg  <= clr_hit ? 3'h0 : clr_reg + {2'h0, clr_reg != 3'h7};
         en_reg   <= (reg_wr && reg_addr == 8'h40) ? reg_wdata[1] : en_reg;
         seen_reg <= seen_reg | $rose(sample_en);
      end
   end
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("rdata moved");
   a_scale_copy: assert property (reg_wr && reg_addr == 8'h40 |->
      ##2 supply_scale_5v == $past(reg_wdata[7], 2)) else $error("scale copy");
   a_track_len: assert property ($rose(sample_en) |->
      sample_en [*8] ##1 sample_en ##1 !sample_en) else $error("track length");
   a_first_trial: assert property ($fell(sample_en) |->
      dac_code == {1'b1, {(N_BITS-1){1'b0}}}) else $error("first trial");
   a_conv_period: assert property ($rose(sample_en) && seen_reg |->
      per_reg == CONV_CYCLES - 1) else $error("period");
   a_chan_sixteen: assert property ($changed(mux_sel_supply) |-> conv_reg == 5'd16)
      else $error("channel count");
   a_alert_gated: assert property (alert_oe |-> en_reg || $past(en_reg))
      else $error("alert ungated");
   a_alert_release: assert property ($fell(alert_oe) |-> clr_reg < 3'h4)
      else $error("alert release");
   c_alert_set: cover property ($rose(alert_oe));
   c_alert_clear: cover property ($fell(alert_oe));
   c_scale_5v: cover property ($rose(supply_scale_5v));
endmodule

bind vmadc_monitor vmadc_monitor_chk #(.N_BITS(N_BITS), .CONV_CYCLES(CONV_CYCLES)) i_chk (
   .ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .mux_sel_supply,
   .supply_scale_5v, .sample_en, .dac_code, .alert_oe);

/* File: testbench/vmadc_monitor_tb.sv */
// Self-checking testbench for the voltage monitor
module vmadc_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk   = 1'b0;
   logic       rst       = 1'b1;
   logic [7:0] reg_addr  = 8'h00;
   logic       reg_wr    = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_rd    = 1'b0;
   logic [9:0] vin_code  = 10'h300;
   logic [9:0] vsup_code = 10'h258;
   wire  [7:0] reg_rdata;
   wire  [9:0] dac_code;
   wire  [9:0] supply_reading;
   wire        comp_ge_pin, mux_sel_supply, supply_scale_5v, sample_en, alert_oe;
   int         fail_count      = 0;
   int         samples_checked = 0;
   always #4 ref_clk = ~ref_clk;
   vmadc_monitor #(.N_BITS(10), .CONV_CYCLES(100)) i_dut (.ref_clk, .rst, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rd, .reg_rdata, .comp_ge_pin, .mux_sel_supply, .supply_scale_5v,
      .sample_en, .dac_code, .supply_reading, .alert_oe);
   vmadc_afe_model i_afe (.mux_sel_supply, .dac_code, .vin_code, .vsup_code, .comp_ge_pin);
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      cyc(1);
      reg_wr    = 1'b0;
      cyc(1);
   endtask
   // Read data holds until the next read, so a late look is safe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd   = 1'b1;
      cyc(1);
      reg_rd   = 1'b0;
      cyc(1);
      chk("rdata", {2'b00, exp}, {2'b00, reg_rdata});
   endtask
   // A 2.5 V measurement ends when the channel turns to the supply
   task automatic meas(input int n);
      repeat (n) @(posedge mux_sel_supply);
      cyc(4);
   endtask
   task automatic t_reset;
      rdchk(8'h20, 8'h00);
      rdchk(8'h44, 8'h00);
      rdchk(8'h45, 8'hff);
      rdchk(8'h41, 8'h00);
      rdchk(8'h3f, 8'h00);
      wr(8'h20, 8'h5a);
      cyc(1400);
      rdchk(8'h20, 8'h00);
   endtask
   task automatic t_meas;
      meas(1);
      rdchk(8'h20, 8'hc0);
      @(negedge mux_sel_supply);
      cyc(4);
      chk("supply", 10'h258, supply_reading);
   endtask
   task automatic t_codes;
      logic [9:0] vin[3] = '{10'h100, 10'h200, 10'h3ff};
      logic [7:0] exp[3] = '{8'h40, 8'h80, 8'hff};
      for (int i = 0; i < 3; i++) begin
         vin_code = vin[i];
         meas(2);
         rdchk(8'h20, exp[i]);
      end
   endtask
   task automatic t_limits;
      vin_code = 10'h300;
      wr(8'h44, 8'hc1);
      wr(8'h40, 8'h80);
      meas(2);
      chk("scale", 10'h001, {9'h000, supply_scale_5v});
      chk("alert", 10'h000, {9'h000, alert_oe});
      wr(8'h40, 8'h82);
      cyc(1);
      chk("alert", 10'h001, {9'h000, alert_oe});
      rdchk(8'h41, 8'h01);
      wr(8'h44, 8'h00);
      wr(8'h45, 8'hbf);
      meas(1);
      rdchk(8'h41, 8'h03);
      rdchk(8'h41, 8'h02);
      wr(8'h45, 8'hff);
      meas(1);
      chk("alert", 10'h001, {9'h000, alert_oe});
      rdchk(8'h41, 8'h02);
      cyc(2);
      chk("alert", 10'h000, {9'h000, alert_oe});
   endtask
   task automatic end_sim;
      $display("Compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      cyc(12);
      rst = 1'b0;
      t_reset;
      t_meas;
      t_codes;
      t_limits;
      end_sim;
   end
   // Run needs about 34000 cycles
   initial begin
      cyc(60000);
      fail_count++;
      end_sim;
   end
endmodule
